// ===== inc/rst_seq_pkg.sv
package rst_seq_pkg;

    // ==================================================
    // Register map and bus widths
    localparam int          ADDR_W       = 8;
    localparam int          DATA_W       = 32;
    localparam int          CNT_W        = 13;
    localparam logic [7:0]  OFF_STATUS   = 8'h00;
    localparam logic [7:0]  OFF_MASK     = 8'h04;
    localparam logic [7:0]  OFF_CONTROL  = 8'h08;
    localparam logic [7:0]  OFF_RESULT   = 8'h0c;
    localparam logic [7:0]  OFF_INTCTL   = 8'h10;
    localparam logic [7:0]  OFF_CCR      = 8'h14;

    // ==================================================
    // Field positions
    localparam int          ST_POR       = 0;
    localparam int          ST_WDOG      = 1;
    localparam int          ST_CLKMON    = 2;
    localparam int          ST_EXT       = 3;
    localparam int          ST_RELEASE   = 4;
    localparam int          CTL_WDOG_EN  = 0;
    localparam int          CTL_CMON_EN  = 1;
    localparam int          IC_ENABLE    = 0;
    localparam int          IC_EDGE      = 1;
    localparam int          CCR_I        = 0;
    localparam int          CCR_X        = 1;

    // ==================================================
    // Reset values
    localparam logic [4:0]  STATUS_RST   = 5'h01;
    localparam logic [4:0]  MASK_RST     = 5'h00;
    localparam logic [1:0]  CONTROL_RST  = 2'h0;
    localparam logic [1:0]  INTCTL_RST   = 2'h1;
    localparam logic [1:0]  CCR_RST      = 2'h3;

    // ==================================================
    // Timing counts, in oscillator cycles and bus cycles
    localparam logic [12:0] STARTUP_CYC  = 13'h1000;
    localparam logic [12:0] DRIVE_TICKS  = 13'h0010;
    localparam logic [12:0] SAMPLE_TICKS = 13'h0009;
    localparam logic [12:0] CNT_ONE      = 13'h0001;

    // ==================================================
    // Vector selection
    localparam logic [1:0]  VEC_NORMAL   = 2'h0;
    localparam logic [1:0]  VEC_CLKMON   = 2'h1;
    localparam logic [1:0]  VEC_WDOG     = 2'h2;
    localparam logic [15:0] ADDR_NORMAL  = 16'hfffe;
    localparam logic [15:0] ADDR_CLKMON  = 16'hfffc;
    localparam logic [15:0] ADDR_WDOG    = 16'hfffa;

    typedef enum logic [2:0] {S_STARTUP, S_DRIVE, S_WAIT, S_HOLD, S_RUN} state_type;

endpackage

// ===== inc/timer_if.sv
`timescale 1ns/10ps
interface timer_if;
    logic                      start;
    logic                      use_tick;
    logic [rst_seq_pkg::CNT_W-1:0] length;
    logic                      done;
    logic                      busy;
    modport owner (output start, output use_tick, output length, input done, input busy);
    modport timer (input start, input use_tick, input length, output done, output busy);
endinterface

// ===== rtl/bus_clock_divider.sv
`timescale 1ns/10ps
module bus_clock_divider
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Divided clock
    output logic      bus_clk,
    output logic      tick
);
    import rst_seq_pkg::*;

    logic bus_clk_ff;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            bus_clk_ff <= 1'b0;
        else
            bus_clk_ff <= ~bus_clk_ff;
    end

    assign bus_clk = bus_clk_ff;
    assign tick    = bus_clk_ff;

    bus_clk_half_a: assert property (@(posedge clk) disable iff (rst)
        tick |=> !tick ##1 tick)
        else $error("bus clock is not half the oscillator rate");

endmodule

// ===== rtl/delay_timer.sv
`timescale 1ns/10ps
module delay_timer
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic tick,
    // Owner side
    timer_if.timer    tm
);
    import rst_seq_pkg::*;

    logic [CNT_W-1:0] cnt_ff;
    logic             busy_ff;
    logic             use_tick_ff;
    wire              step = busy_ff && (tick || !use_tick_ff);

    assign tm.done = step && (cnt_ff == CNT_ONE);
    assign tm.busy = busy_ff;

    // Comes out of power-on already counting the start-up wait
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_ff      <= STARTUP_CYC;
            busy_ff     <= 1'b1;
            use_tick_ff <= 1'b0;
        end
        else if (tm.start)
        begin
            cnt_ff      <= tm.length;
            busy_ff     <= 1'b1;
            use_tick_ff <= tm.use_tick;
        end
        else if (step)
        begin
            cnt_ff      <= cnt_ff - CNT_ONE;
            busy_ff     <= !tm.done;
        end
    end

    timer_stop_a: assert property (@(posedge clk) disable iff (rst)
        (busy_ff && !use_tick_ff && cnt_ff == CNT_ONE) |=> !busy_ff || cnt_ff != CNT_ONE)
        else $error("timer did not stop at the end of its count");

endmodule

// ===== rtl/reset_sequencer.sv
`timescale 1ns/10ps
module reset_sequencer
(
    // Clock and power-on reset
    input  wire logic                           clk,
    input  wire logic                           rst,
    // Register port
    input  wire logic [rst_seq_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [rst_seq_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                           reg_wr,
    input  wire logic                           reg_rd,
    output logic      [rst_seq_pkg::DATA_W-1:0] reg_rdata,
    output logic                                irq,
    // Failure sources
    input  wire logic                           watchdog_timeout,
    input  wire logic                           clock_fail,
    // Open-drain reset pin
    input  wire logic                           reset_pin_in,
    output logic                                reset_pin_out,
    output logic                                reset_pin_oe,
    // Mode pins
    input  wire logic                           mode_select_pin_a,
    input  wire logic                           mode_select_pin_b,
    input  wire logic                           special_mode_select_n,
    output logic                                mode_pulldown_en,
    output logic      [2:0]                     mode_latched,
    // Processor side
    output logic                                core_reset,
    output logic      [1:0]                     vector_select,
    output logic      [15:0]                    vector_addr,
    output logic                                maskable_interrupt_enable,
    output logic                                irq_edge_mode,
    output logic                                ccr_irq_mask,
    output logic                                ccr_nonmaskable_interrupt_pin_mask,
    output logic                                bus_clock_output
);
    import rst_seq_pkg::*;

    // ==================================================
    // Helpers
    function automatic logic [1:0] pick_vector(input logic pin, input logic cm,
                                               input logic wd);
        logic [1:0] sel;
        sel = VEC_NORMAL;
        if (pin && cm)
            sel = VEC_CLKMON;
        else if (pin && wd)
            sel = VEC_WDOG;
        return sel;
    endfunction

    function automatic logic [15:0] vec_addr(input logic [1:0] sel);
        logic [15:0] a;
        a = ADDR_NORMAL;
        if (sel == VEC_CLKMON)
            a = ADDR_CLKMON;
        else if (sel == VEC_WDOG)
            a = ADDR_WDOG;
        return a;
    endfunction

    // ==================================================
    // Declarations
    state_type   state_ff;
    state_type   nxt_state;
    logic        wd_flag_ff;
    logic        cm_flag_ff;
    logic [1:0]  vec_ff;
    logic [1:0]  nxt_vec;
    logic        oe_ff;
    logic        pd_ff;
    logic [2:0]  mode_ff;
    logic [4:0]  status_ff;
    logic [4:0]  mask_ff;
    logic [1:0]  ctrl_ff;
    logic [1:0]  intctl_ff;
    logic [1:0]  ccr_ff;
    logic [DATA_W-1:0] rdata_ff;
    logic        tick;
    timer_if     tm ();

    // ==================================================
    // Sub-blocks
    bus_clock_divider u_div
    (
        .clk     (clk),
        .rst     (rst),
        .bus_clk (bus_clock_output),
        .tick    (tick)
    );

    delay_timer u_timer
    (
        .clk  (clk),
        .rst  (rst),
        .tick (tick),
        .tm   (tm)
    );

    // ==================================================
    // Events
    wire wd_evt      = watchdog_timeout && ctrl_ff[CTL_WDOG_EN];
    wire cm_evt      = clock_fail && ctrl_ff[CTL_CMON_EN];
    wire in_run      = (state_ff == S_RUN);
    wire ext_low     = in_run && !reset_pin_in;
    wire sample_now  = (state_ff == S_WAIT) && tm.done;
    wire sample_low  = sample_now && !reset_pin_in;
    wire enter_run   = !in_run && (nxt_state == S_RUN);
    wire flag_clear  = sample_low || enter_run;

    // Entry needs no clock edge
    assign core_reset = rst || !reset_pin_in || wd_evt || cm_evt || !in_run;

    // ==================================================
    // Sequencer
    always_comb
    begin
        nxt_state   = state_ff;
        tm.start    = 1'b0;
        tm.use_tick = 1'b1;
        // Spare tick: a start between ticks would cut the first bus cycle short
        tm.length   = DRIVE_TICKS + CNT_ONE;
        case (state_ff)
            S_STARTUP:
                if (tm.done)
                begin
                    nxt_state = S_DRIVE;
                    tm.start  = 1'b1;
                end
            S_DRIVE:
                if (tm.done)
                begin
                    nxt_state = S_WAIT;
                    tm.start  = 1'b1;
                    tm.length = SAMPLE_TICKS;
                end
            S_WAIT:
                if (tm.done)
                    nxt_state = reset_pin_in ? S_RUN : S_HOLD;
            S_HOLD:
                if (reset_pin_in)
                    nxt_state = S_RUN;
            S_RUN:
                if (wd_evt || ext_low)
                begin
                    nxt_state = S_DRIVE;
                    tm.start  = 1'b1;
                end
            default:
                nxt_state = S_STARTUP;
        endcase
        if (cm_evt)
        begin
            nxt_state   = S_STARTUP;
            tm.start    = 1'b1;
            tm.use_tick = 1'b0;
            tm.length   = STARTUP_CYC;
        end
    end

    assign nxt_vec = sample_now ? pick_vector(reset_pin_in, cm_flag_ff, wd_flag_ff)
                                : vec_ff;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_ff <= S_STARTUP;
            vec_ff   <= VEC_NORMAL;
            oe_ff    <= 1'b1;
            pd_ff    <= 1'b1;
        end
        else
        begin
            state_ff <= nxt_state;
            vec_ff   <= nxt_vec;
            oe_ff    <= (nxt_state == S_STARTUP) || (nxt_state == S_DRIVE);
            pd_ff    <= (nxt_state != S_RUN);
        end
    end

    // Set wins over the clear
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wd_flag_ff <= 1'b0;
            cm_flag_ff <= 1'b0;
        end
        else
        begin
            wd_flag_ff <= wd_evt || (wd_flag_ff && !flag_clear);
            cm_flag_ff <= cm_evt || (cm_flag_ff && !flag_clear);
        end
    end

    assign reset_pin_out = 1'b0;
    assign reset_pin_oe  = oe_ff;
    assign vector_select = vec_ff;
    assign vector_addr   = vec_addr(vec_ff);

    // ==================================================
    // Mode pins
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            mode_ff <= 3'h0;
        else if (!in_run)
            mode_ff <= {special_mode_select_n, mode_select_pin_b, mode_select_pin_a};
    end

    assign mode_pulldown_en = pd_ff;
    assign mode_latched     = mode_ff;

    // ==================================================
    // Register port
    wire hit_status  = (reg_addr == OFF_STATUS);
    wire hit_mask    = (reg_addr == OFF_MASK);
    wire hit_control = (reg_addr == OFF_CONTROL);
    wire hit_result  = (reg_addr == OFF_RESULT);
    wire hit_intctl  = (reg_addr == OFF_INTCTL);
    wire hit_ccr     = (reg_addr == OFF_CCR);

    wire [4:0] w1c_bits = (reg_wr && hit_status) ? reg_wdata[4:0] : 5'h00;
    wire [4:0] ev_bits  = {enter_run, sample_low || ext_low, cm_evt, wd_evt, 1'b0};

    wire [DATA_W-1:0] rd_mux =
        hit_status  ? {27'h0, status_ff} :
        hit_mask    ? {27'h0, mask_ff} :
        hit_control ? {30'h0, ctrl_ff} :
        hit_result  ? {24'h0, mode_ff, state_ff, vec_ff} :
        hit_intctl  ? {30'h0, intctl_ff} :
        hit_ccr     ? {30'h0, ccr_ff} : 32'h0;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            status_ff <= STATUS_RST;
            mask_ff   <= MASK_RST;
            ctrl_ff   <= CONTROL_RST;
            rdata_ff  <= 32'h0;
        end
        else
        begin
            status_ff <= ev_bits | (status_ff & ~w1c_bits);
            rdata_ff  <= reg_rd ? rd_mux : 32'h0;
            if (reg_wr && hit_mask)
                mask_ff <= reg_wdata[4:0];
            if (reg_wr && hit_control)
                ctrl_ff <= reg_wdata[1:0];
        end
    end

    // Interrupt settings are forced back on every reset
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            intctl_ff <= INTCTL_RST;
            ccr_ff    <= CCR_RST;
        end
        else if (core_reset)
        begin
            intctl_ff <= INTCTL_RST;
            ccr_ff    <= CCR_RST;
        end
        else if (reg_wr && hit_intctl)
            intctl_ff <= reg_wdata[1:0];
        else if (reg_wr && hit_ccr)
            ccr_ff <= {ccr_ff[CCR_X] & reg_wdata[CCR_X], reg_wdata[CCR_I]};
    end

    assign reg_rdata                 = rdata_ff;
    assign irq                       = |(status_ff & mask_ff);
    assign maskable_interrupt_enable = intctl_ff[IC_ENABLE];
    assign irq_edge_mode             = intctl_ff[IC_EDGE];
    assign ccr_irq_mask              = ccr_ff[CCR_I];
    assign ccr_nonmaskable_interrupt_pin_mask             = ccr_ff[CCR_X];

    // ==================================================
    // Checks
    pin_low_entry_a: assert property (@(posedge clk) disable iff (rst)
        !reset_pin_in |-> core_reset)
        else $error("external low did not hold the core in reset");

    wdog_drive_a: assert property (@(posedge clk) disable iff (rst)
        (in_run && wd_evt && !cm_evt) |=> reset_pin_oe && state_ff == S_DRIVE)
        else $error("watchdog timeout did not drive the reset pin");

    drive_pin_a: assert property (@(posedge clk) disable iff (rst)
        (state_ff == S_DRIVE) |-> reset_pin_oe)
        else $error("reset pin released during drive interval");

    sample_delay_a: assert property (@(posedge clk) disable iff (rst)
        ($fell(reset_pin_oe) && !cm_evt) |-> (state_ff == S_WAIT)[*8])
        else $error("pin sampled too early after release");

    ext_clear_a: assert property (@(posedge clk) disable iff (rst)
        (sample_low && !cm_evt && !wd_evt) |=> !cm_flag_ff && !wd_flag_ff
                                               && vec_ff == VEC_NORMAL)
        else $error("external reset did not clear flags");

    clkmon_vec_a: assert property (@(posedge clk) disable iff (rst)
        (sample_now && reset_pin_in && cm_flag_ff) |=> vector_select == VEC_CLKMON)
        else $error("clock monitor vector not chosen");

    wdog_vec_a: assert property (@(posedge clk) disable iff (rst)
        (sample_now && reset_pin_in && !cm_flag_ff && wd_flag_ff)
            |=> vector_select == VEC_WDOG && vector_addr == ADDR_WDOG)
        else $error("watchdog vector not chosen");

    normal_vec_a: assert property (@(posedge clk) disable iff (rst)
        (sample_now && reset_pin_in && !cm_flag_ff && !wd_flag_ff)
            |=> vector_select == VEC_NORMAL)
        else $error("normal vector not chosen");

    mode_pull_a: assert property (@(posedge clk) disable iff (rst)
        (state_ff != S_RUN) |-> mode_pulldown_en)
        else $error("mode pull-downs off during reset");

    irq_reset_a: assert property (@(posedge clk) disable iff (rst)
        core_reset |=> maskable_interrupt_enable && !irq_edge_mode && ccr_irq_mask)
        else $error("maskable interrupt not reset to level and masked");

    xmask_hold_a: assert property (@(posedge clk) disable iff (rst)
        (!core_reset && !ccr_nonmaskable_interrupt_pin_mask) |=> !ccr_nonmaskable_interrupt_pin_mask)
        else $error("nonmaskable mask set again by software");

endmodule

// ===== test/reset_supervisor.sv
`timescale 1ns/10ps
module reset_supervisor
(
    // Clock
    input  wire logic       clk,
    // Device side of the reset wire
    input  wire logic       reset_pin_out,
    input  wire logic       reset_pin_oe,
    output logic            reset_pin_in,
    // Scenario control
    input  wire logic       hold_low,
    input  wire logic [3:0] rise_cycles
);
    logic [3:0] rise_cnt_ff;
    wire logic  pulled_low;

    // ==========
    // Wired reset level with pull-up
    assign pulled_low = (reset_pin_oe && !reset_pin_out) || hold_low;

    // Pull-up needs some cycles to charge the wire after release
    always @(posedge clk)
    begin
        if (pulled_low)
            rise_cnt_ff <= 4'h0;
        else if (rise_cnt_ff != rise_cycles)
            rise_cnt_ff <= rise_cnt_ff + 4'h1;
    end

    assign reset_pin_in = !pulled_low && (rise_cnt_ff == rise_cycles);
endmodule

// ===== test/tb.sv
`timescale 1ns/10ps
module tb;
    import rst_seq_pkg::*;

    // ==========
    // Signals
    logic              clk, rst, reg_wr, reg_rd, irq, watchdog_timeout, clock_fail;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata;
    logic              reset_pin_in, reset_pin_out, reset_pin_oe, hold_low;
    logic              mode_select_pin_a, mode_select_pin_b, special_mode_select_n;
    logic              mode_pulldown_en, core_reset, maskable_interrupt_enable;
    logic              irq_edge_mode, ccr_irq_mask, ccr_nonmaskable_interrupt_pin_mask, bus_clock_output;
    logic [2:0]        mode_latched;
    logic [1:0]        vector_select;
    logic [15:0]       vector_addr;
    logic [3:0]        rise_cycles;
    logic [31:0]       d;
    int                n_mismatch, samples_checked, hi, lo;

    reset_sequencer dut_u
    (
        .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
        .watchdog_timeout(watchdog_timeout), .clock_fail(clock_fail),
        .reset_pin_in(reset_pin_in), .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe),
        .mode_select_pin_a(mode_select_pin_a), .mode_select_pin_b(mode_select_pin_b),
        .special_mode_select_n(special_mode_select_n), .mode_pulldown_en(mode_pulldown_en),
        .mode_latched(mode_latched), .core_reset(core_reset), .vector_select(vector_select),
        .vector_addr(vector_addr), .maskable_interrupt_enable(maskable_interrupt_enable),
        .irq_edge_mode(irq_edge_mode), .ccr_irq_mask(ccr_irq_mask),
        .ccr_nonmaskable_interrupt_pin_mask(ccr_nonmaskable_interrupt_pin_mask), .bus_clock_output(bus_clock_output)
    );

    reset_supervisor sup_u
    (
        .clk(clk), .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe),
        .reset_pin_in(reset_pin_in), .hold_low(hold_low), .rise_cycles(rise_cycles)
    );

    always #4 clk = ~clk;

    // ==========
    // Shared tasks
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_rng(input string what, input int lo_v, input int hi_v, input int got);
        samples_checked++;
        if (got < lo_v || got > hi_v)
        begin
            n_mismatch++;
            $display("mismatch %s expected %0d..%0d seen %0d", what, lo_v, hi_v, got);
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic pulse(input logic wd, input logic cm);
        @(posedge clk);
        watchdog_timeout <= wd;
        clock_fail       <= cm;
        @(posedge clk);
        watchdog_timeout <= 1'b0;
        clock_fail       <= 1'b0;
        #1;
    endtask

    // Cycles of pin drive, then cycles until the core runs
    task automatic run_seq;
        hi = 0;
        lo = 0;
        while (reset_pin_oe === 1'b1 && hi < 6000)
        begin
            @(posedge clk);
            #1;
            hi++;
        end
        while (core_reset === 1'b1 && lo < 200)
        begin
            @(posedge clk);
            #1;
            lo++;
        end
        chk("core running", 32'h0, core_reset);
    endtask

    task automatic chk_defaults;
        chk("irq enable", 32'h1, maskable_interrupt_enable);
        chk("irq edge mode", 32'h0, irq_edge_mode);
        chk("irq mask", 32'h1, ccr_irq_mask);
        chk("nonmaskable_interrupt_pin mask", 32'h1, ccr_nonmaskable_interrupt_pin_mask);
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ==========
    // Scenarios
    task automatic t_power_on;
        @(posedge clk);
        rst <= 1'b0;
        #1;
        run_seq();
        chk_rng("startup and drive", 4127, 4132, hi);
        chk_rng("sample delay", 16, 21, lo);
        chk("vector", VEC_NORMAL, vector_select);
        chk("vector addr", ADDR_NORMAL, vector_addr);
        chk("pulldown", 32'h0, mode_pulldown_en);
        @(posedge clk);
        mode_select_pin_a <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk("mode", 32'h5, mode_latched);
        repeat (4)
        begin
            d[0] = bus_clock_output;
            @(posedge clk);
            #1;
            chk("bus clock", !d[0], bus_clock_output);
        end
        reg_read(OFF_STATUS);
        chk("status power-on", 32'h1, d[ST_POR]);
        reg_read(OFF_RESULT);
        chk("result", {24'h0, 3'h5, S_RUN, VEC_NORMAL}, d);
        $display("test power_on done");
    endtask

    task automatic t_watchdog;
        reg_write(OFF_CONTROL, 32'h3);
        pulse(1'b1, 1'b0);
        chk("drive on watchdog", 32'h1, reset_pin_oe);
        run_seq();
        chk_rng("drive length", 32, 34, hi);
        chk_rng("sample delay", 16, 21, lo);
        chk("vector", VEC_WDOG, vector_select);
        chk("vector addr", ADDR_WDOG, vector_addr);
        chk("irq masked", 32'h0, irq);
        reg_write(OFF_MASK, 32'h1 << ST_WDOG);
        #1;
        chk("irq raised", 32'h1, irq);
        reg_write(OFF_STATUS, 32'h1 << ST_WDOG);
        #1;
        chk("irq cleared", 32'h0, irq);
        reg_read(8'h20);
        chk("unmapped read", 32'h0, d);
        reg_read(OFF_INTCTL);
        chk("interrupt control", 32'h1, d);
        reg_write(OFF_CCR, 32'h0);
        reg_read(OFF_CCR);
        chk("flags by software", 32'h0, d);
        $display("test watchdog done");
    endtask

    task automatic t_clock_monitor;
        pulse(1'b1, 1'b1);
        chk("drive on monitor", 32'h1, reset_pin_oe);
        run_seq();
        chk_rng("startup and drive", 4127, 4132, hi);
        chk("vector", VEC_CLKMON, vector_select);
        chk("vector addr", ADDR_CLKMON, vector_addr);
        chk_defaults();
        $display("test clock_monitor done");
    endtask

    task automatic t_external;
        @(posedge clk);
        hold_low <= 1'b1;
        #1;
        chk("entry on pin low", 32'h1, core_reset);
        pulse(1'b1, 1'b0);
        repeat (150) @(posedge clk);
        hold_low <= 1'b0;
        #1;
        run_seq();
        chk("vector", VEC_NORMAL, vector_select);
        chk("vector addr", ADDR_NORMAL, vector_addr);
        $display("test external done");
    endtask

    task automatic t_slow_rise;
        @(posedge clk);
        rise_cycles <= 4'hc;
        pulse(1'b1, 1'b0);
        run_seq();
        chk("vector", VEC_WDOG, vector_select);
        $display("test slow_rise done");
    endtask

    task automatic t_async_entry;
        @(posedge clk);
        rst <= 1'b1;
        #1;
        chk("async drive", 32'h1, reset_pin_oe);
        chk("async core reset", 32'h1, core_reset);
        chk_defaults();
        @(posedge clk);
        rst <= 1'b0;
        #1;
        run_seq();
        chk_rng("startup and drive", 4127, 4132, hi);
        chk("vector", VEC_NORMAL, vector_select);
        $display("test async_entry done");
    endtask

    initial
    begin
        clk = 1'b0;
        rst = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        watchdog_timeout = 1'b0;
        clock_fail = 1'b0;
        hold_low = 1'b0;
        rise_cycles = 4'h0;
        mode_select_pin_a = 1'b1;
        mode_select_pin_b = 1'b0;
        special_mode_select_n = 1'b1;
        n_mismatch = 0;
        samples_checked = 0;
        repeat (3) @(posedge clk);
        #1;
        chk("drive in reset", 32'h1, reset_pin_oe);
        chk("pulldown in reset", 32'h1, mode_pulldown_en);
        chk_defaults();
        t_power_on();
        t_watchdog();
        t_clock_monitor();
        t_external();
        t_slow_rise();
        t_async_entry();
        end_sim();
    end

    initial
    begin
        #(40000 * 8);
        n_mismatch++;
        $display("watchdog expired");
        end_sim();
    end
endmodule
